// [pps_pkg.sv]
package pps_pkg;
  // register word offsets on the avalon bus
  localparam logic [3:0] ADDR_SEL_OFS = 4'h0;
  localparam logic [3:0] PIN_EN_OFS = 4'h1;
  localparam logic [3:0] BUF_STAT_OFS = 4'h2;
  localparam logic [3:0] PAD_CFG_OFS = 4'h3;
  localparam logic [3:0] OUT_ONE_OFS = 4'h4;
  localparam logic [3:0] OUT_TWO_OFS = 4'h5;
  localparam logic [3:0] IN_ONE_OFS = 4'h6;
  localparam logic [3:0] IN_TWO_OFS = 4'h7;
  localparam logic [3:0] IRQ_STAT_OFS = 4'h8;
  localparam logic [3:0] IRQ_EN_OFS = 4'h9;
  localparam logic [3:0] IRQ_CLR_OFS = 4'hA;
  localparam logic [3:0] SLAVE_CTL_OFS = 4'hB;

  // status and config field positions
  localparam int INPUT_ALL_FULL_BIT = 15;
  localparam int INPUT_OVERFLOW_BIT = 14;
  localparam int INPUT_SLOT_LSB = 8;
  localparam int OUTPUT_ALL_EMPTY_BIT = 7;
  localparam int OUTPUT_UNDERFLOW_BIT = 6;
  localparam int OUTPUT_SLOT_LSB = 0;
  localparam int INPUT_LEVEL_SELECT_BIT = 0;
  localparam int CHIP_SELECT_ONE_BIT = 14;
  localparam int SLAVE_AUTOINC_BIT = 0;

  // reset values, write masks and the unmapped read value
  localparam logic [15:0] ADDR_SEL_RST = 16'h0000;
  localparam logic [15:0] PIN_EN_RST = 16'h0000;
  localparam logic [15:0] PAD_CFG_RST = 16'h0000;
  localparam logic [15:0] ADDR_SEL_MASK = 16'h47FF;
  localparam logic [15:0] PAD_CFG_MASK = 16'h0003;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

  localparam int NUM_SLOTS = 4;
  localparam int NUM_EVENTS = 4;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [1:0] sel;
    logic [7:0] data;
  } pps_host_req_t;
endpackage

// [pps_slot.sv]
`timescale 1ns/1ps
module pps_slot
  import pps_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [7:0] host_data,
  input wire logic sw_wr,
  input wire logic sw_rd,
  input wire logic [7:0] sw_data,
  output logic [7:0] in_byte_q,
  output logic [7:0] out_byte_q,
  output logic in_full_q,
  output logic out_empty_q,
  output logic overflow,
  output logic underflow
);
  assign overflow = host_wr && in_full_q;
  assign underflow = host_rd && out_empty_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      in_byte_q <= 8'h00;
      out_byte_q <= 8'h00;
      in_full_q <= 1'b0;
      out_empty_q <= 1'b1;
    end else begin
      if (host_wr && !in_full_q) begin
        in_byte_q <= host_data;
      end
      if (host_wr) begin
        in_full_q <= 1'b1;
      end else if (sw_rd) begin
        in_full_q <= 1'b0;
      end
      if (sw_wr) begin
        out_byte_q <= sw_data;
        out_empty_q <= 1'b0;
      end else if (host_rd) begin
        out_empty_q <= 1'b1;
      end
    end
  end
endmodule

// [pps_top.sv]
// Summary of operation
// - host write to full slot sets overflow
// - host read of empty slot sets underflow
// - two select lines pick one of four bytes
// - level select bit: ttl set, schmitt clear
// - output slot flag reads one while empty
// - four-byte buffer with select and autoincrement
//
// Added by the designer: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
module pps_top
  import pps_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic host_cs_pin,
  input wire logic host_rd_pin,
  input wire logic host_wr_pin,
  input wire logic [1:0] slave_byte_select_lines,
  input wire logic [7:0] host_data_in,
  output logic [7:0] host_data_out,
  output logic host_data_oe,
  output logic input_level_select,
  output logic irq
);
  // pin synchronisers
  logic [11:0] pin_s1_q;
  logic [11:0] pin_s2_q;
  logic rd_prev_q;
  logic wr_prev_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_s1_q <= 12'h000;
      pin_s2_q <= 12'h000;
      rd_prev_q <= 1'b0;
      wr_prev_q <= 1'b0;
    end else begin
      pin_s1_q <= {host_cs_pin, host_rd_pin, host_wr_pin, slave_byte_select_lines,
                   host_data_in[6:0]};
      pin_s2_q <= pin_s1_q;
      rd_prev_q <= pin_s2_q[10] && pin_s2_q[11];
      wr_prev_q <= pin_s2_q[9] && pin_s2_q[11];
    end
  end
  logic data7_s1_q;
  logic data7_s2_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      data7_s1_q <= 1'b0;
      data7_s2_q <= 1'b0;
    end else begin
      data7_s1_q <= host_data_in[7];
      data7_s2_q <= data7_s1_q;
    end
  end

  // registers
  logic [15:0] addr_sel_q;
  logic [15:0] pin_en_q;
  logic [15:0] pad_cfg_q;
  logic slave_autoinc_q;
  logic [1:0] auto_ptr_q;
  logic [NUM_EVENTS-1:0] irq_stat_q;
  logic [NUM_EVENTS-1:0] irq_en_q;
  logic input_overflow_flag_q;
  logic output_underflow_flag_q;

  // host request, qualified by chip select
  pps_host_req_t req;
  wire rd_level = pin_s2_q[10] && pin_s2_q[11];
  wire wr_level = pin_s2_q[9] && pin_s2_q[11];
  wire [1:0] pin_sel = pin_s2_q[8:7];
  wire [1:0] req_sel = slave_autoinc_q ? auto_ptr_q : pin_sel;
  assign req = '{
    rd: rd_level && !rd_prev_q,
    wr: wr_level && !wr_prev_q,
    sel: req_sel,
    data: {data7_s2_q, pin_s2_q[6:0]}
  };

  // bus decode
  wire bus_req = avs_read || avs_write;
  logic ack_q;
  wire acc = bus_req && !ack_q;
  wire wr_acc = avs_write && acc;
  wire rd_acc = avs_read && acc;
  wire lo_en = avs_byteenable[0];
  wire hi_en = avs_byteenable[1];
  wire hit_addr = avs_address == ADDR_SEL_OFS;
  wire hit_pin = avs_address == PIN_EN_OFS;
  wire hit_stat = avs_address == BUF_STAT_OFS;
  wire hit_pad = avs_address == PAD_CFG_OFS;
  wire hit_out1 = avs_address == OUT_ONE_OFS;
  wire hit_out2 = avs_address == OUT_TWO_OFS;
  wire hit_in1 = avs_address == IN_ONE_OFS;
  wire hit_in2 = avs_address == IN_TWO_OFS;
  wire hit_ist = avs_address == IRQ_STAT_OFS;
  wire hit_ien = avs_address == IRQ_EN_OFS;
  wire hit_iclr = avs_address == IRQ_CLR_OFS;
  wire hit_ctl = avs_address == SLAVE_CTL_OFS;

  // four byte slots
  logic [NUM_SLOTS-1:0] in_full;
  logic [NUM_SLOTS-1:0] out_empty;
  logic [NUM_SLOTS-1:0] ovf;
  logic [NUM_SLOTS-1:0] unf;
  logic [7:0] in_bytes [NUM_SLOTS];
  logic [7:0] out_bytes [NUM_SLOTS];
  genvar g;
  generate
    for (g = 0; g < NUM_SLOTS; g++) begin : g_slot
      wire sel_me = req.sel == 2'(g);
      wire pair_wr = (g < 2) ? (wr_acc && hit_out1) : (wr_acc && hit_out2);
      wire pair_rd = (g < 2) ? (rd_acc && hit_in1) : (rd_acc && hit_in2);
      wire lane_en = (g % 2 == 0) ? lo_en : hi_en;
      pps_slot u_slot (
        .clk(clk),
        .rst(rst),
        .host_wr(req.wr && sel_me),
        .host_rd(req.rd && sel_me),
        .host_data(req.data),
        .sw_wr(pair_wr && lane_en),
        .sw_rd(pair_rd && lane_en),
        .sw_data((g % 2 == 0) ? avs_writedata[7:0] : avs_writedata[15:8]),
        .in_byte_q(in_bytes[g]),
        .out_byte_q(out_bytes[g]),
        .in_full_q(in_full[g]),
        .out_empty_q(out_empty[g]),
        .overflow(ovf[g]),
        .underflow(unf[g])
      );
    end
  endgenerate

  wire any_ovf = |ovf;
  wire any_unf = |unf;
  wire input_all_full_flag = &in_full;
  wire output_all_empty = &out_empty;
  wire [15:0] stat_word = {input_all_full_flag, input_overflow_flag_q, 2'b00, in_full,
                           output_all_empty, output_underflow_flag_q, 2'b00, out_empty};

  // interrupt events: overflow, underflow, input all full, output all empty
  logic all_full_prev_q;
  logic all_empty_prev_q;
  wire [NUM_EVENTS-1:0] events = {output_all_empty && !all_empty_prev_q,
                                  input_all_full_flag && !all_full_prev_q, any_unf, any_ovf};
  wire [NUM_EVENTS-1:0] clr_bits = (wr_acc && hit_iclr) ? avs_writedata[3:0] : 4'h0;

  // software write of zero to a status error flag bit clears that flag (set wins)
  wire stat_wr_hi = wr_acc && hit_stat && hi_en;
  wire stat_wr_lo = wr_acc && hit_stat && lo_en;
  wire ovf_d = any_ovf || (input_overflow_flag_q &&
               !(stat_wr_hi && !avs_writedata[INPUT_OVERFLOW_BIT]));
  wire unf_d = any_unf || (output_underflow_flag_q &&
               !(stat_wr_lo && !avs_writedata[OUTPUT_UNDERFLOW_BIT]));

  always_ff @(posedge clk) begin
    if (rst) begin
      input_overflow_flag_q <= 1'b0;
      output_underflow_flag_q <= 1'b0;
      irq_stat_q <= 4'h0;
      all_full_prev_q <= 1'b0;
      all_empty_prev_q <= 1'b1;
    end else begin
      input_overflow_flag_q <= ovf_d;
      output_underflow_flag_q <= unf_d;
      irq_stat_q <= events | (irq_stat_q & ~clr_bits);
      all_full_prev_q <= input_all_full_flag;
      all_empty_prev_q <= output_all_empty;
    end
  end

  // config registers
  wire [15:0] be_mask = {{8{hi_en}}, {8{lo_en}}};
  always_ff @(posedge clk) begin
    if (rst) begin
      addr_sel_q <= ADDR_SEL_RST;
      pin_en_q <= PIN_EN_RST;
      pad_cfg_q <= PAD_CFG_RST;
      irq_en_q <= 4'h0;
      slave_autoinc_q <= 1'b0;
    end else if (wr_acc) begin
      if (hit_addr) begin
        addr_sel_q <= ((avs_writedata[15:0] & be_mask) | (addr_sel_q & ~be_mask))
                      & ADDR_SEL_MASK;
      end
      if (hit_pin) begin
        pin_en_q <= (avs_writedata[15:0] & be_mask) | (pin_en_q & ~be_mask);
      end
      if (hit_pad && lo_en) begin
        pad_cfg_q <= avs_writedata[15:0] & PAD_CFG_MASK;
      end
      if (hit_ien && lo_en) begin
        irq_en_q <= avs_writedata[3:0];
      end
      if (hit_ctl && lo_en) begin
        slave_autoinc_q <= avs_writedata[SLAVE_AUTOINC_BIT];
      end
    end
  end

  // auto-increment pointer walks the four slots
  always_ff @(posedge clk) begin
    if (rst) begin
      auto_ptr_q <= 2'b00;
    end else if (slave_autoinc_q && (req.rd || req.wr)) begin
      auto_ptr_q <= auto_ptr_q + 2'b01;
    end else if (!slave_autoinc_q) begin
      auto_ptr_q <= 2'b00;
    end
  end

  // read mux
  wire [31:0] rd_mux =
    hit_addr ? {16'h0000, addr_sel_q} :
    hit_pin ? {16'h0000, pin_en_q} :
    hit_stat ? {16'h0000, stat_word} :
    hit_pad ? {16'h0000, pad_cfg_q} :
    hit_out1 ? {16'h0000, out_bytes[1], out_bytes[0]} :
    hit_out2 ? {16'h0000, out_bytes[3], out_bytes[2]} :
    hit_in1 ? {16'h0000, in_bytes[1], in_bytes[0]} :
    hit_in2 ? {16'h0000, in_bytes[3], in_bytes[2]} :
    hit_ist ? {28'h000_0000, irq_stat_q} :
    hit_ien ? {28'h000_0000, irq_en_q} :
    hit_ctl ? {31'h0000_0000, slave_autoinc_q} :
    UNMAPPED_READ;

  // one wait cycle: waitrequest drops in the cycle after the request
  always_ff @(posedge clk) begin
    if (rst) begin
      ack_q <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else begin
      ack_q <= acc;
      avs_waitrequest <= !acc;
      if (rd_acc) begin
        avs_readdata <= rd_mux;
      end
    end
  end

  // host data out and pad outputs
  wire [7:0] host_byte = out_bytes[req.sel];
  always_ff @(posedge clk) begin
    if (rst) begin
      host_data_out <= 8'h00;
      host_data_oe <= 1'b0;
      input_level_select <= 1'b0;
      irq <= 1'b0;
    end else begin
      if (req.rd) begin
        host_data_out <= host_byte;
      end
      host_data_oe <= rd_level;
      input_level_select <= pad_cfg_q[INPUT_LEVEL_SELECT_BIT];
      irq <= |(irq_stat_q & irq_en_q);
    end
  end
endmodule

// [pps_top_asserts.sv]
`timescale 1ns/1ps
module pps_top_asserts
  import pps_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic host_cs_pin,
  input wire logic host_rd_pin,
  input wire logic host_data_oe,
  input wire logic input_level_select,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic fresh_q;
  wire touch = avs_write || host_cs_pin || (avs_read && avs_address != BUF_STAT_OFS);
  wire rd_ok = avs_read && !avs_waitrequest;
  wire wr_ok = avs_write && !avs_waitrequest;
  wire pad_wr = wr_ok && avs_address == PAD_CFG_OFS && avs_byteenable[0];
  wire en_off = wr_ok && avs_address == IRQ_EN_OFS && avs_writedata[3:0] == 4'h0;
  // untouched since reset
  always_ff @(posedge clk) begin
    if (rst) begin
      fresh_q <= 1'b1;
    end else if (touch) begin
      fresh_q <= 1'b0;
    end
  end
  wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered after one wait cycle");
  wait_stand_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  unmapped_zero_a: assert property (rd_ok && avs_address > SLAVE_CTL_OFS |->
    avs_readdata == UNMAPPED_READ) else $error("unmapped read not zero");
  level_sel_a: assert property (pad_wr |=> input_level_select == $past(avs_writedata[0]))
    else $error("input level select not following pad cfg");
  oe_cause_a: assert property (host_data_oe |-> $past(host_cs_pin && host_rd_pin, 3))
    else $error("host data driven without host read");
  oe_follow_a: assert property (host_data_oe == $past(host_cs_pin && host_rd_pin, 3))
    else $error("host data enable not following host read");
  stat_reset_a: assert property (fresh_q && rd_ok && avs_address == BUF_STAT_OFS |->
    avs_readdata[15:0] == 16'h008F) else $error("status wrong after reset");
  fresh_irq_a: assert property (fresh_q |-> !irq)
    else $error("irq without event");
  irq_mask_a: assert property (en_off |-> ##2 !irq)
    else $error("irq not masked");
  cover property (host_cs_pin && host_rd_pin);
  cover property ($rose(irq));
  cover property (host_data_oe);
endmodule
bind pps_top pps_top_asserts u_pps_top_asserts (.clk, .rst, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .host_cs_pin, .host_rd_pin,
  .host_data_oe, .input_level_select, .irq);

// [pps_host_model.sv]
`timescale 1ns/1ps
module pps_host_model
  import pps_pkg::*;
(
  input wire logic clk,
  input wire logic [7:0] host_data_out,
  output logic host_cs_pin,
  output logic host_rd_pin,
  output logic host_wr_pin,
  output logic [1:0] slave_byte_select_lines,
  output logic [7:0] host_data_in
);
  initial begin
    host_cs_pin = 1'b0;
    host_rd_pin = 1'b0;
    host_wr_pin = 1'b0;
    slave_byte_select_lines = 2'h0;
    host_data_in = 8'h00;
  end
  // one host cycle held for hold clocks
  task automatic xfer(input pps_host_req_t r, input int hold, output logic [7:0] got);
    host_cs_pin <= 1'b1;
    host_rd_pin <= r.rd;
    host_wr_pin <= r.wr;
    slave_byte_select_lines <= r.sel;
    host_data_in <= r.data;
    repeat (hold) @(posedge clk);
    got = host_data_out;
    host_cs_pin <= 1'b0;
    host_rd_pin <= 1'b0;
    host_wr_pin <= 1'b0;
    // released lines do not keep the old value
    slave_byte_select_lines <= ~r.sel;
    host_data_in <= ~r.data;
    repeat (4) @(posedge clk);
  endtask
endmodule

// [pps_top_tb.sv]
`timescale 1ns/1ps
module pps_top_tb
  import pps_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic [3:0] avs_byteenable = 4'h3;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata, rdat;
  logic avs_waitrequest, host_cs_pin, host_rd_pin, host_wr_pin, host_data_oe;
  logic input_level_select, irq;
  logic [1:0] sel;
  logic [7:0] din, dout, got;
  int miscompares = 0;
  int num_checks = 0;
  always #25 clk = ~clk;
  pps_top u_pps_top (.clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .host_cs_pin, .host_rd_pin, .host_wr_pin,
    .slave_byte_select_lines(sel), .host_data_in(din), .host_data_out(dout), .host_data_oe,
    .input_level_select, .irq);
  pps_host_model u_pps_host_model (.clk, .host_data_out(dout), .host_cs_pin, .host_rd_pin,
    .host_wr_pin, .slave_byte_select_lines(sel), .host_data_in(din));
  task automatic give_verdict;
    if (miscompares == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] a, input logic [15:0] e, input string what);
    num_checks++;
    if (a !== e) begin
      miscompares++;
      $display("Error at %0t ns: %s", $time, what);
    end
  endtask
  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    rdat = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
    if (n >= 40) begin
      miscompares++;
      give_verdict();
    end
  endtask
  task automatic rd(input logic [3:0] a);
    av(1'h0, a, 32'h0000_0000);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    av(1'h1, a, d);
  endtask
  task automatic host(input logic w, input logic [1:0] s, input logic [7:0] d, input int hold);
    pps_host_req_t r;
    r = '{rd: !w, wr: w, sel: s, data: d};
    u_pps_host_model.xfer(r, hold, got);
  endtask
  task automatic t_reset;
    rd(BUF_STAT_OFS); chk(rdat[15:0], 16'h008F, "status after reset");
    wr(4'hC, 32'hFFFF_FFFF);
    rd(4'hC); chk(rdat[15:0], 16'h0000, "unmapped read");
    rd(PAD_CFG_OFS); chk(rdat[15:0], PAD_CFG_RST, "pad cfg reset");
    rd(ADDR_SEL_OFS); chk(rdat[15:0], ADDR_SEL_RST, "addr reg reset");
    wr(ADDR_SEL_OFS, 32'h0000_FFFF);
    rd(ADDR_SEL_OFS); chk(rdat[15:0], 16'h47FF, "addr reg unused bits");
  endtask
  task automatic t_level;
    for (int i = 1; i >= 0; i--) begin
      wr(PAD_CFG_OFS, 32'(i));
      repeat (2) @(posedge clk);
      chk(input_level_select, i[0], "input level select");
    end
  endtask
  task automatic t_autoinc;
    wr(SLAVE_CTL_OFS, 32'h0000_0001);
    for (int i = 0; i < 4; i++) host(1'h1, 2'h3, 8'(8'hC0 + i), 6);
    rd(IN_ONE_OFS); chk(rdat[15:0], 16'hC1C0, "autoinc pair one");
    rd(IN_TWO_OFS); chk(rdat[15:0], 16'hC3C2, "autoinc pair two");
    wr(SLAVE_CTL_OFS, 32'h0000_0000);
  endtask
  task automatic t_select;
    for (int i = 0; i < 3; i++) host(1'h1, i[1:0], 8'(8'hA0 + i), 6);
    rd(BUF_STAT_OFS); chk(rdat[15:8], 8'h07, "three slots full");
    host(1'h1, 2'h3, 8'hA3, 9);
    rd(BUF_STAT_OFS); chk(rdat[15:8], 8'h8F, "all slots full");
    rd(IN_ONE_OFS); chk(rdat[15:0], 16'hA1A0, "pair one bytes");
    rd(IN_TWO_OFS); chk(rdat[15:0], 16'hA3A2, "pair two bytes");
    rd(BUF_STAT_OFS); chk(rdat[15:8], 8'h00, "read empties slots");
  endtask
  task automatic t_overflow;
    wr(IRQ_EN_OFS, 32'h0000_0001);
    host(1'h1, 2'h0, 8'h5A, 6);
    host(1'h1, 2'h0, 8'hA5, 6);
    rd(BUF_STAT_OFS); chk(rdat[15:8], 8'h41, "overflow flag");
    chk(irq, 1'h1, "overflow irq");
    rd(IRQ_STAT_OFS); chk(rdat[3:0], 4'h5, "overflow and all-full events");
    wr(IRQ_EN_OFS, 32'h0000_0000);
    repeat (3) @(posedge clk);
    chk(irq, 1'h0, "irq masked");
    wr(IRQ_EN_OFS, 32'h0000_0001);
    repeat (3) @(posedge clk);
    chk(irq, 1'h1, "irq unmasked");
    wr(IRQ_CLR_OFS, 32'h0000_0001);
    repeat (3) @(posedge clk);
    chk(irq, 1'h0, "irq cleared");
    wr(BUF_STAT_OFS, 32'h0000_0000);
    rd(IN_ONE_OFS); chk(rdat[7:0], 8'h5A, "byte kept on overflow");
    rd(BUF_STAT_OFS); chk(rdat[15:8], 8'h00, "overflow cleared");
  endtask
  task automatic t_output;
    wr(OUT_ONE_OFS, 32'h0000_3412);
    rd(BUF_STAT_OFS); chk(rdat[7:0], 8'h0C, "slots loaded");
    host(1'h0, 2'h1, 8'h00, 6); chk(got, 8'h34, "host high byte");
    host(1'h0, 2'h0, 8'h00, 6); chk(got, 8'h12, "host low byte");
    rd(BUF_STAT_OFS); chk(rdat[7:0], 8'h8F, "slots empty");
    host(1'h0, 2'h0, 8'h00, 6);
    rd(BUF_STAT_OFS); chk(rdat[7:0], 8'hCF, "underflow flag");
    rd(IRQ_STAT_OFS); chk(rdat[3:0], 4'hE, "underflow and empty events");
    wr(IRQ_CLR_OFS, 32'h0000_000F);
    rd(IRQ_STAT_OFS); chk(rdat[3:0], 4'h0, "events cleared");
    wr(BUF_STAT_OFS, 32'h0000_0000);
    rd(BUF_STAT_OFS); chk(rdat[7:0], 8'h8F, "underflow cleared");
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_level();
    t_autoinc();
    t_select();
    t_overflow();
    t_output();
    give_verdict();
  end
endmodule
